// [inc/isat_pkg.sv]
// isat_pkg: register map, field positions, reset values and counts for the
// interrupt sources and periodic tick block.
// assumes an apb slave with 32-bit data, one aligned word per register.
package isat_pkg;

    // register byte offsets on apb
    localparam logic [7:0] OFF_CTRL0    = 8'h00;  // enables and flags, group 0
    localparam logic [7:0] OFF_CTRL1    = 8'h04;  // enables and flags, group 1
    localparam logic [7:0] OFF_TICK     = 8'h08;  // periodic tick divider control
    localparam logic [7:0] OFF_TOUCHOV  = 8'h0C;  // touch counter overflow flags
    localparam logic [7:0] OFF_STATUS   = 8'h10;  // vector, stack and request state

    // ctrl0 field positions
    localparam int CTRL0_GIE_BIT   = 0;
    localparam int CTRL0_TKE_BIT   = 2;
    localparam int CTRL0_TE_BIT    = 3;
    localparam int CTRL0_TKF_BIT   = 5;
    localparam int CTRL0_TF_BIT    = 6;

    // ctrl1 field positions
    localparam int CTRL1_SE_BIT    = 0;
    localparam int CTRL1_PTE_BIT   = 1;
    localparam int CTRL1_DE_BIT    = 2;
    localparam int CTRL1_AE_BIT    = 3;
    localparam int CTRL1_SF_BIT    = 4;
    localparam int CTRL1_PTF_BIT   = 5;
    localparam int CTRL1_DF_BIT    = 6;
    localparam int CTRL1_AF_BIT    = 7;

    // tick divider control field
    localparam int TICK_SEL_LO     = 4;
    localparam int TICK_SEL_HI     = 5;

    // touch overflow register fields
    localparam int TOV_FREQ_BIT    = 0;
    localparam int TOV_AUX_BIT     = 1;

    // reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [1:0] TICK_RESET  = 2'b00;

    // tick periods in tick source clock cycles
    localparam int TICK_DIV_W      = 13;
    localparam logic [12:0] TICK_P0 = 13'h0400;  // 1024
    localparam logic [12:0] TICK_P1 = 13'h0800;  // 2048
    localparam logic [12:0] TICK_P2 = 13'h1000;  // 4096
    localparam logic [12:0] TICK_P3 = 13'h1FFF;  // 8192 counted as 0..8191

    // source numbering, lowest index wins
    localparam int NSRC            = 6;
    localparam int SRC_TOUCH       = 0;
    localparam int SRC_TIMER       = 1;
    localparam int SRC_SERIAL      = 2;
    localparam int SRC_TICK        = 3;
    localparam int SRC_EEPROM      = 4;
    localparam int SRC_CONV        = 5;

    // vector handed to the core when nothing is pending; a pending source's vector is its index
    localparam logic [2:0] VEC_NONE = 3'h7;

endpackage : isat_pkg

// [inc/isat_tick_if.sv]
// isat_tick_if: carries the tick period select and the tick overflow pulse
// between the top and the tick divider.
// assumes one clock domain; tick source clock arrives as an enable pulse.
`timescale 1ns/10ps
interface isat_tick_if;
    logic [1:0] period_sel;  // tick period select field
    logic       overflow;    // one-cycle pulse on divider wrap

    modport ctrl (output period_sel, input overflow);
    modport div  (input period_sel, output overflow);
endinterface : isat_tick_if

// [verilog/isat_tick_div.sv]
// isat_tick_div: periodic tick divider with selectable terminal count.
// assumes tick_src_en is a one-cycle pulse per tick source clock cycle,
// synchronous to pclk.
`timescale 1ns/10ps
module isat_tick_div (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tick_src_en,
    isat_tick_if.div  tk
);

    logic [isat_pkg::TICK_DIV_W-1:0] cnt_reg;
    logic [isat_pkg::TICK_DIV_W-1:0] cnt_next;
    logic [isat_pkg::TICK_DIV_W-1:0] last_cnt;
    logic                            wrap;

    // terminal count from the period select
    assign last_cnt = (tk.period_sel == 2'b00) ? isat_pkg::TICK_P0 - 13'h0001 :
                      (tk.period_sel == 2'b01) ? isat_pkg::TICK_P1 - 13'h0001 :
                      (tk.period_sel == 2'b10) ? isat_pkg::TICK_P2 - 13'h0001 :
                                                 isat_pkg::TICK_P3;
    // >= so a shorter period picked mid-count still wraps at once
    assign wrap     = tick_src_en && (cnt_reg >= last_cnt);
    assign cnt_next = wrap ? '0 : (tick_src_en ? cnt_reg + 13'h0001 : cnt_reg);

    ////////////////////////////////////////////////////////////////////////////
    // divider counter and overflow pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg     <= '0;
            tk.overflow <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            tk.overflow <= wrap;
        end
    end

endmodule : isat_tick_div

// [verilog/isat_top.sv]
// isat_top: interrupt request flags, enables, vectoring, wake-up and
// periodic tick for a small controller core, reached over apb.
// assumes peripheral events are one-cycle pulses synchronous to pclk and the
// core takes a vector by pulsing irq_ack while irq_req is high.
//
// Summary of operation
// - tick divider overflow sets tick flag
// - select bits 5:4 pick 1024..8192 period
// - unused tick control bits read zero
// - vector only if flag, enables, stack free
// - service clears source flag and global enable
// - timer overflow sets timer flag
// - eeprom write end sets eeprom flag
// - touch slot overflow sets touch flag
// - touch frequency overflow flag, software cleared
// - module zero aux overflow flag, software cleared
// - serial byte, match, timeout set serial flag
// - conversion end sets conversion flag
// - any flag rising edge wakes device
// - flags hold until serviced or cleared
// - irq return sets global enable, plain leaves
// - full stack blocks all acknowledges
// - requests while disabled stay latched
`timescale 1ns/10ps
module isat_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // event sources, one-cycle pulses
    input  wire logic        tick_src_en,
    input  wire logic        timer_ovf,
    input  wire logic        eeprom_wr_done,
    input  wire logic        touch_slot_ovf,
    input  wire logic        touch_freq_ovf,
    input  wire logic        touch_aux_ovf,
    input  wire logic        serial_rx_byte,
    input  wire logic        serial_tx_byte,
    input  wire logic        serial_addr_match,
    input  wire logic        serial_timeout,
    input  wire logic        conversion_end,
    // core side
    input  wire logic        stack_full,
    input  wire logic        irq_ack,
    input  wire logic        return_from_irq_instr,
    input  wire logic        plain_return_instr,
    input  wire logic        low_power,
    output logic             irq_req,
    output logic      [2:0]  irq_vector,
    output logic             wake_up
);

    localparam int N = isat_pkg::NSRC;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [N-1:0] flag_reg;
    logic [N-1:0] flag_next;
    logic [N-1:0] en_reg;
    logic [N-1:0] en_next;
    logic         gie_reg;
    logic         gie_next;
    logic [1:0]   tick_sel_reg;
    logic         freq_ovf_reg;
    logic         aux_ovf_reg;
    logic         wake_reg;
    logic [31:0]  rdata_reg;

    isat_tick_if tk ();

    isat_tick_div u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick_src_en (tick_src_en),
        .tk          (tk.div)
    );

    assign tk.period_sel = tick_sel_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait state, unmapped address answers pslverr
    logic wr_acc;
    logic rd_acc;
    logic hit_c0;
    logic hit_c1;
    logic hit_tk;
    logic hit_tov;
    logic hit_st;
    logic mapped;
    logic lane0;

    assign hit_c0  = paddr == isat_pkg::OFF_CTRL0;
    assign hit_c1  = paddr == isat_pkg::OFF_CTRL1;
    assign hit_tk  = paddr == isat_pkg::OFF_TICK;
    assign hit_tov = paddr == isat_pkg::OFF_TOUCHOV;
    assign hit_st  = paddr == isat_pkg::OFF_STATUS;
    assign mapped  = hit_c0 | hit_c1 | hit_tk | hit_tov | hit_st;
    assign lane0   = pstrb[0];
    assign wr_acc  = psel && penable && pwrite && mapped && lane0;
    assign rd_acc  = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////////
    // event collection per source
    logic [N-1:0] ev;

    assign ev[isat_pkg::SRC_TOUCH]  = touch_slot_ovf;
    assign ev[isat_pkg::SRC_TIMER]  = timer_ovf;
    assign ev[isat_pkg::SRC_SERIAL] = serial_rx_byte | serial_tx_byte
                                    | serial_addr_match | serial_timeout;
    assign ev[isat_pkg::SRC_TICK]   = tk.overflow;
    assign ev[isat_pkg::SRC_EEPROM] = eeprom_wr_done;
    assign ev[isat_pkg::SRC_CONV]   = conversion_end;

    ////////////////////////////////////////////////////////////////////////////
    // priority pick: lowest index pending and enabled wins
    function automatic logic [2:0] pick (input logic [N-1:0] pend);
        logic [2:0] v;
        v = isat_pkg::VEC_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = 3'(i);
            end
        end
        return v;
    endfunction : pick

    logic [N-1:0] pend;
    logic [2:0]   win;
    logic         take;
    logic [N-1:0] svc_clr;

    assign pend    = flag_reg & en_reg;
    // no vector while disabled or stack full; pending flags simply wait
    assign irq_req = gie_reg && (|pend) && !stack_full;
    assign win     = pick(pend);
    assign take    = irq_req && irq_ack;
    // one-hot clear of the serviced source only
    assign svc_clr = take ? (6'h01 << win) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // software views of flag and enable bits in the two control words
    logic [7:0] c0_view;
    logic [7:0] c1_view;

    assign c0_view = {1'b0, flag_reg[isat_pkg::SRC_TIMER], flag_reg[isat_pkg::SRC_TOUCH], 1'b0,
                      en_reg[isat_pkg::SRC_TIMER], en_reg[isat_pkg::SRC_TOUCH], 1'b0, gie_reg};
    assign c1_view = {flag_reg[isat_pkg::SRC_CONV], flag_reg[isat_pkg::SRC_EEPROM],
                      flag_reg[isat_pkg::SRC_TICK], flag_reg[isat_pkg::SRC_SERIAL],
                      en_reg[isat_pkg::SRC_CONV], en_reg[isat_pkg::SRC_EEPROM],
                      en_reg[isat_pkg::SRC_TICK], en_reg[isat_pkg::SRC_SERIAL]};

    // written values of the same layout
    logic [N-1:0] wflag;
    logic [N-1:0] wen;
    logic [N-1:0] wmask;

    assign wflag = {pwdata[isat_pkg::CTRL1_AF_BIT], pwdata[isat_pkg::CTRL1_DF_BIT],
                    pwdata[isat_pkg::CTRL1_PTF_BIT], pwdata[isat_pkg::CTRL1_SF_BIT],
                    pwdata[isat_pkg::CTRL0_TF_BIT], pwdata[isat_pkg::CTRL0_TKF_BIT]};
    assign wen   = {pwdata[isat_pkg::CTRL1_AE_BIT], pwdata[isat_pkg::CTRL1_DE_BIT],
                    pwdata[isat_pkg::CTRL1_PTE_BIT], pwdata[isat_pkg::CTRL1_SE_BIT],
                    pwdata[isat_pkg::CTRL0_TE_BIT], pwdata[isat_pkg::CTRL0_TKE_BIT]};
    // sources 0..1 live in ctrl0, 2..5 in ctrl1
    assign wmask = wr_acc ? (hit_c0 ? 6'h03 : (hit_c1 ? 6'h3C : 6'h00)) : 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // next state: software write, then service clear, then events win
    always_comb begin
        flag_next = (flag_reg & ~wmask) | (wflag & wmask);
        flag_next = flag_next & ~svc_clr;
        flag_next = flag_next | ev;                         // set beats clear
        en_next   = (en_reg & ~wmask) | (wen & wmask);
        gie_next  = gie_reg;
        if (wr_acc && hit_c0) begin
            gie_next = pwdata[isat_pkg::CTRL0_GIE_BIT];
        end
        if (take) begin
            gie_next = 1'b0;
        end else if (return_from_irq_instr) begin
            gie_next = 1'b1;
        end
        // plain return leaves the global enable as it is
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags, enables, global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= '0;
            en_reg   <= '0;
            gie_reg  <= isat_pkg::CTRL0_RESET[isat_pkg::CTRL0_GIE_BIT];
        end else begin
            flag_reg <= flag_next;
            en_reg   <= en_next;
            gie_reg  <= gie_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tick period select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_sel_reg <= isat_pkg::TICK_RESET;
        end else if (wr_acc && hit_tk) begin
            tick_sel_reg <= pwdata[isat_pkg::TICK_SEL_HI:isat_pkg::TICK_SEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // touch counter overflow flags; hardware never clears them
    logic freq_next;
    logic aux_next;

    assign freq_next = touch_freq_ovf |
                       (freq_ovf_reg & ~(wr_acc && hit_tov && !pwdata[isat_pkg::TOV_FREQ_BIT]));
    assign aux_next  = touch_aux_ovf |
                       (aux_ovf_reg & ~(wr_acc && hit_tov && !pwdata[isat_pkg::TOV_AUX_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_ovf_reg <= 1'b0;
            aux_ovf_reg  <= 1'b0;
        end else begin
            freq_ovf_reg <= freq_next;
            aux_ovf_reg  <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-up on any flag rising edge, enables ignored
    logic [N+1:0] all_flags_now;
    logic [N+1:0] all_flags_nxt;
    logic         rise;

    assign all_flags_now = {aux_ovf_reg, freq_ovf_reg, flag_reg};
    assign all_flags_nxt = {aux_next, freq_next, flag_next};
    assign rise          = |(all_flags_nxt & ~all_flags_now);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= rise && low_power;
        end
    end

    assign wake_up = wake_reg;

    ////////////////////////////////////////////////////////////////////////////
    // registered vector to the core; only pc is stacked by the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_vector <= isat_pkg::VEC_NONE;
        end else begin
            irq_vector <= pick(flag_next & en_next);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, captured in setup so prdata comes from a flop
    logic [31:0] rmux;

    assign rmux = hit_c0  ? {24'h00_0000, c0_view} :
                  hit_c1  ? {24'h00_0000, c1_view} :
                  hit_tk  ? {24'h00_0000, 2'b00, tick_sel_reg, 4'h0} :
                  hit_tov ? {30'h0000_0000, aux_ovf_reg, freq_ovf_reg} :
                  hit_st  ? {24'h00_0000, stack_full, irq_req, 3'h0, win} :
                            32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
        end else if (rd_acc) begin
            rdata_reg <= rmux;
        end
    end

    assign prdata = rdata_reg;

endmodule : isat_top

// [dv/isat_props.sv]
// isat_props: port-level checks on vectoring, flag holding and wake-up.
// assumes it is bound onto isat_top and sees only that module's ports.
`timescale 1ns/10ps
module isat_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       tick_src_en,
    input wire logic       timer_ovf,
    input wire logic       eeprom_wr_done,
    input wire logic       touch_slot_ovf,
    input wire logic       touch_freq_ovf,
    input wire logic       touch_aux_ovf,
    input wire logic       serial_rx_byte,
    input wire logic       serial_tx_byte,
    input wire logic       serial_addr_match,
    input wire logic       serial_timeout,
    input wire logic       conversion_end,
    input wire logic       stack_full,
    input wire logic       irq_ack,
    input wire logic       return_from_irq_instr,
    input wire logic       low_power,
    input wire logic       irq_req,
    input wire logic [2:0] irq_vector,
    input wire logic       wake_up
);
    ////////////////////////////////////////////////////////////////////////
    // causes that may raise a flag; tick reaches its flag two edges late
    wire logic ev_any = timer_ovf | eeprom_wr_done | touch_slot_ovf | touch_freq_ovf | touch_aux_ovf
                      | serial_rx_byte | serial_tx_byte | serial_addr_match | serial_timeout | conversion_end;
    wire logic apb_wr = psel & penable & pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    property p_full_blocks; stack_full |-> !irq_req; endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("request raised while stack is full");
    property p_ack_clears; irq_req && irq_ack |=> !irq_req; endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("request still up after service");
    property p_plain_ret; irq_req && irq_ack ##1 (!apb_wr && !return_from_irq_instr) |=> !irq_req; endproperty
    a_plain_ret: assert property (p_plain_ret)
        else $error("global enable came back without irq return");
    property p_hold; irq_req && !irq_ack && !apb_wr |=> irq_req || stack_full; endproperty
    a_hold: assert property (p_hold)
        else $error("pending request vanished unserviced");
    property p_vec; irq_req |-> irq_vector < 3'h6; endproperty
    a_vec: assert property (p_vec)
        else $error("request without a valid vector");
    property p_rise_cause;
        $rose(irq_req) |-> $fell(stack_full) || $past(ev_any) || $past(apb_wr) || $past(return_from_irq_instr)
                           || $past(tick_src_en, 2) || $past(tick_src_en, 3);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("request rose with no cause");
    property p_wake;
        wake_up |-> $past(low_power) && ($past(ev_any) || $past(apb_wr) || $past(tick_src_en, 2)
                                         || $past(tick_src_en, 3));
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse with no flag rise");
    property p_lp_gate; !low_power |=> !wake_up; endproperty
    a_lp_gate: assert property (p_lp_gate)
        else $error("wake pulse outside low power");

    // main scenarios reached
    c_wake: cover property (wake_up);
    c_take: cover property (irq_req && irq_ack);
    c_full: cover property (stack_full && ev_any);
endmodule : isat_props

// [dv/isat_core_model.sv]
// isat_core_model: core sequencer stand-in that takes vectors from isat_top.
// assumes one pclk domain; lat sets how long a request waits before ack.
`timescale 1ns/10ps
module isat_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq_req,
    input  wire logic [2:0] irq_vector,
    input  wire logic [3:0] lat,
    output logic            irq_ack,
    output logic      [2:0] took,
    output logic      [7:0] n_taken
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] wait_reg;

    // ack only while the request is still up; a slow core may see it drop
    // only the return address would be stacked, no call made in a handler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack  <= 1'b0;
            wait_reg <= 4'h0;
            took     <= 3'h7;
            n_taken  <= 8'h00;
        end else if (irq_ack) begin
            irq_ack  <= 1'b0;
            wait_reg <= 4'h0;
            if (irq_req) begin
                took    <= irq_vector;
                n_taken <= n_taken + 8'h01;
            end
        end else if (irq_req && wait_reg >= lat) begin
            irq_ack <= 1'b1;
        end else begin
            wait_reg <= irq_req ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : isat_core_model

// [dv/isat_top_tb.sv]
// isat_top_tb: register, event, tick, vectoring and wake tests for isat_top.
// assumes the core model acks requests; peripheral events are pulsed here.
`timescale 1ns/10ps
module isat_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, n_taken;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb, lat;
    logic [9:0]  ev;
    logic        tick_src_en, stack_full, low_power, rti, pret, irq_req, irq_ack, wake_up;
    logic [2:0]  irq_vector, took;
    int          n_fail, checks_done, n_wake, cyc, i, s;
    logic [7:0]  ea [10] = '{8'h00, 8'h04, 8'h00, 8'h0C, 8'h0C, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
    int          eb [10] = '{6, 6, 5, 0, 1, 4, 4, 4, 4, 7};

    isat_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_src_en(tick_src_en), .timer_ovf(ev[0]), .eeprom_wr_done(ev[1]), .touch_slot_ovf(ev[2]),
        .touch_freq_ovf(ev[3]), .touch_aux_ovf(ev[4]), .serial_rx_byte(ev[5]), .serial_tx_byte(ev[6]),
        .serial_addr_match(ev[7]), .serial_timeout(ev[8]), .conversion_end(ev[9]), .stack_full(stack_full),
        .irq_ack(irq_ack), .return_from_irq_instr(rti), .plain_return_instr(pret), .low_power(low_power),
        .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));
    isat_core_model u_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector),
        .lat(lat), .irq_ack(irq_ack), .took(took), .n_taken(n_taken));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic pulse(input logic [9:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 10'h000;
        repeat (3) @(posedge pclk);
    endtask : pulse

    // n back-to-back tick source cycles
    task automatic ticks(input int n);
        @(posedge pclk);
        tick_src_en <= 1'b1;
        repeat (n) @(posedge pclk);
        tick_src_en <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : ticks

    task automatic ret(input logic from_irq);
        @(posedge pclk);
        {rti, pret} <= from_irq ? 2'b10 : 2'b01;
        @(posedge pclk);
        {rti, pret} <= 2'b00;
        repeat (6) @(posedge pclk);
    endtask : ret

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // wake pulse count and hang guard; whole run is near 16k cycles
    always @(posedge pclk) begin
        if (wake_up === 1'b1) n_wake++;
        cyc++;
        if (cyc >= 40000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, tick_src_en, stack_full, low_power, rti, pret} = '0;
        pstrb = 4'hF;
        lat = 4'h3;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        apb(1'b1, 8'h08, 32'h0000_00FF);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(q, 32'h0000_0030);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // every event source except the tick, flag held, then cleared by software
        for (i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            apb(1'b0, ea[i], 32'h0000_0000);
            chk(q >> eb[i], 32'h0000_0001);
            if (ea[i] == 8'h0C) begin
                apb(1'b1, ea[i], 32'h0000_0003);
                apb(1'b0, ea[i], 32'h0000_0000);
                chk(q >> eb[i], 32'h0000_0001);
            end
            apb(1'b1, ea[i], 32'h0000_0000);
            apb(1'b0, ea[i], 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        // each tick period: one pulse short, then exactly on it
        for (s = 0; s < 4; s++) begin
            apb(1'b1, 8'h08, 32'(s) << 4);
            apb(1'b1, 8'h04, 32'h0000_0000);
            ticks((1024 << s) - 1);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk(q, 32'h0000_0000);
            ticks(1);
            apb(1'b0, 8'h04, 32'h0000_0000);
            chk(q, 32'h0000_0020);
        end
        // three requests at once behind a full stack
        apb(1'b1, 8'h00, 32'h0000_000D);
        apb(1'b1, 8'h04, 32'h0000_000F);
        @(posedge pclk);
        stack_full <= 1'b1;
        pulse(10'h221);
        chk({31'h0, irq_req}, 32'h0000_0000);
        chk({24'h0, n_taken}, 32'h0000_0000);
        @(posedge pclk);
        stack_full <= 1'b0;
        repeat (8) @(posedge pclk);
        chk({24'h0, n_taken}, 32'h0000_0001);
        chk({29'h0, took}, 32'h0000_0001);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_000C);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_009F);
        ret(1'b0);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_000C);
        lat <= 4'h0;
        ret(1'b1);
        chk({29'h0, took}, 32'h0000_0002);
        ret(1'b1);
        chk({29'h0, took}, 32'h0000_0005);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_000F);
        // wake on rise only, ctrl1 enables off; a preset flag gives none
        apb(1'b1, 8'h04, 32'h0000_0000);
        chk(n_wake, 32'h0000_0000);
        @(posedge pclk);
        low_power <= 1'b1;
        pulse(10'h002);
        chk(n_wake, 32'h0000_0001);
        pulse(10'h002);
        chk(n_wake, 32'h0000_0001);
        results();
    end
endmodule : isat_top_tb

bind isat_top isat_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .tick_src_en(tick_src_en), .timer_ovf(timer_ovf), .eeprom_wr_done(eeprom_wr_done),
    .touch_slot_ovf(touch_slot_ovf), .touch_freq_ovf(touch_freq_ovf), .touch_aux_ovf(touch_aux_ovf),
    .serial_rx_byte(serial_rx_byte), .serial_tx_byte(serial_tx_byte), .serial_addr_match(serial_addr_match),
    .serial_timeout(serial_timeout), .conversion_end(conversion_end), .stack_full(stack_full),
    .irq_ack(irq_ack), .return_from_irq_instr(return_from_irq_instr), .low_power(low_power),
    .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));
